// ===== pta_pkg.sv
// constants, register map and message decode for the ptp time adjust and rx classifier
// assumes a 32-bit register port and a byte-wide receive frame stream
package pta_pkg;

	// ==================================================================
	// register map (byte addresses)
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_SYSTIME_LOW = 8'h00;
	localparam logic [7:0] REG_SYSTIME_HIGH = 8'h04;
	localparam logic [7:0] REG_INC_CFG = 8'h08;
	localparam logic [7:0] REG_OFF_LOW = 8'h0c;
	localparam logic [7:0] REG_OFF_HIGH = 8'h10;
	localparam logic [7:0] REG_RX_CTRL = 8'h14;
	localparam logic [7:0] REG_RX_TS_LOW = 8'h18;
	localparam logic [7:0] REG_RX_TS_HIGH = 8'h1c;
	localparam logic [7:0] REG_RX_SEQ = 8'h20;
	localparam logic [7:0] REG_RX_SRC_LOW = 8'h24;
	localparam logic [7:0] REG_RX_SRC_HIGH = 8'h28;
	localparam logic [7:0] REG_IRQ_STAT = 8'h2c;
	localparam logic [7:0] REG_IRQ_MASK = 8'h30;
	localparam logic [7:0] REG_ETYPE = 8'h34;
	localparam logic [7:0] REG_LAST_MSG = 8'h38;

	// ==================================================================
	// fields and reset values
	localparam int INC_PERIOD_LSB = 24;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_V2_BIT = 1;
	localparam int CTRL_MSG_LSB = 8;
	localparam int OFF_SIGN_BIT = 31;
	localparam int IRQ_W = 3;
	localparam int IRQ_STAMPED = 0;
	localparam int IRQ_PTP_SEEN = 1;
	localparam int IRQ_MISSED = 2;
	localparam logic [31:0] INC_CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] RX_CTRL_RESET = 32'h0000_0000;
	localparam logic [15:0] ETYPE_RESET = 16'h88f7;

	// ==================================================================
	// frame layout
	localparam logic [15:0] ETYPE_VLAN = 16'h8100;
	localparam logic [15:0] ETYPE_IP4 = 16'h0800;
	localparam logic [15:0] ETYPE_IP6 = 16'h86dd;
	localparam logic [7:0] IP_PROTO_UDP = 8'h11;
	localparam logic [15:0] UDP_PORT_EVENT = 16'h013f;
	localparam logic [15:0] UDP_PORT_GENERAL = 16'h0140;
	localparam logic [10:0] L2_BASE = 11'h00e;
	localparam logic [10:0] VLAN_BASE = 11'h012;
	localparam logic [10:0] IP4_PROTO_OFF = 11'h009;
	localparam logic [10:0] IP6_NH_OFF = 11'h006;
	localparam logic [10:0] IP6_HDR_LEN = 11'h028;
	localparam logic [10:0] UDP_PORT_OFF = 11'h002;
	localparam logic [10:0] UDP_HDR_LEN = 11'h008;
	localparam logic [10:0] PTP_ID_OFF = 11'h000;
	localparam logic [10:0] PTP_VER_OFF = 11'h001;
	localparam logic [10:0] PTP_SRC_FIRST = 11'h016;
	localparam logic [10:0] PTP_SRC_LAST = 11'h01d;
	localparam logic [10:0] PTP_SEQ_FIRST = 11'h01e;
	localparam logic [10:0] PTP_SEQ_LAST = 11'h01f;
	localparam logic [10:0] PTP_CTRL_OFF = 11'h020;

	// ==================================================================
	// message codes
	localparam logic [3:0] PTP_VER1 = 4'h1;
	localparam logic [3:0] PTP_VER2 = 4'h2;
	localparam logic [7:0] V1_EVENT_LAST = 8'h01;
	localparam logic [7:0] V1_CODE_LAST = 8'h04;
	localparam logic [3:0] V2_EVENT_LAST = 4'h3;
	localparam logic [3:0] V2_PATH_REQ = 4'h2;
	localparam logic [3:0] V2_PATH_RESP = 4'h3;
	localparam logic [3:0] V2_UNUSED_LO = 4'h4;
	localparam logic [3:0] V2_UNUSED_LO_END = 4'h7;
	localparam logic [3:0] V2_UNUSED_HI = 4'he;

	typedef enum logic [1:0] {KIND_NONE, KIND_L2, KIND_IP4, KIND_IP6} pta_kind_t;

	// returns {reserved, event} for a message code of either version
	function automatic logic [1:0] pta_msg_class(input logic is_v2, input logic [7:0] code);
		logic rsv;
		logic evt;
		if (is_v2) begin
			rsv = (code[3:0] >= V2_UNUSED_LO && code[3:0] <= V2_UNUSED_LO_END) ||
				(code[3:0] >= V2_UNUSED_HI);
			evt = code[3:0] <= V2_EVENT_LAST;
		end else begin
			rsv = code > V1_CODE_LAST;
			evt = code <= V1_EVENT_LAST;
		end
		return {rsv, evt};
	endfunction : pta_msg_class

endpackage : pta_pkg

// ===== pta_ptp_core.sv
// register file, system time adjust and receive ptp classifier with timestamp capture
// assumes a byte stream from the receive datapath, synchronous to core_clk
// How it works
// - high word write adds offset to time
// - v1 only over udp ipv4; v2 wider
// - check version before choosing type field
// - v1: compare control byte at 32
// - v2: compare message id at byte 0
// - v1 codes 0-4 known, rest reserved
// - v2 codes 0-3 event, 8-d general
// - v2 mode always stamps path delay messages
// - other header fields share positions both versions
// - stamp frozen until read; later frames skipped
// - udp ports 319 event, 320 general
// - time advances by increment every period
module pta_ptp_core
	import pta_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// receive frame stream
	input wire logic rx_valid,
	input wire logic rx_sof,
	input wire logic rx_eof,
	input wire logic [7:0] rx_data,
	// interrupt
	output logic irq
);

	// ==================================================================
	// register port decode
	logic wr_inc, wr_sys_high, wr_off_low, wr_off_high, wr_ctrl, wr_mask, wr_etype;
	logic rd_sys_low, rd_ts_high, rd_stat;
	logic [31:0] inc_cfg_reg, off_low_reg, off_high_reg, ctrl_reg, sys_shadow_reg;
	logic [15:0] etype_reg;
	logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_ev;
	logic [63:0] sys_time;
	logic [31:0] rd_next;

	assign wr_inc = reg_write && reg_addr == REG_INC_CFG;
	assign wr_sys_high = reg_write && reg_addr == REG_SYSTIME_HIGH;
	assign wr_off_low = reg_write && reg_addr == REG_OFF_LOW;
	assign wr_off_high = reg_write && reg_addr == REG_OFF_HIGH;
	assign wr_ctrl = reg_write && reg_addr == REG_RX_CTRL;
	assign wr_mask = reg_write && reg_addr == REG_IRQ_MASK;
	assign wr_etype = reg_write && reg_addr == REG_ETYPE;
	assign rd_sys_low = reg_read && reg_addr == REG_SYSTIME_LOW;
	assign rd_ts_high = reg_read && reg_addr == REG_RX_TS_HIGH;
	assign rd_stat = reg_read && reg_addr == REG_IRQ_STAT;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			inc_cfg_reg <= INC_CFG_RESET;
			off_low_reg <= 32'h0;
			off_high_reg <= 32'h0;
			ctrl_reg <= RX_CTRL_RESET;
			irq_mask_reg <= '0;
			etype_reg <= ETYPE_RESET;
		end else begin
			if (wr_inc) inc_cfg_reg <= reg_wdata;
			if (wr_off_low) off_low_reg <= reg_wdata;
			if (wr_off_high) off_high_reg <= reg_wdata;
			if (wr_ctrl) ctrl_reg <= reg_wdata;
			if (wr_mask) irq_mask_reg <= reg_wdata[IRQ_W-1:0];
			if (wr_etype) etype_reg <= reg_wdata[15:0];
		end
	end

	// high word read returns the copy taken when the low word was read
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sys_shadow_reg <= 32'h0;
		end else if (rd_sys_low) begin
			sys_shadow_reg <= sys_time[63:32];
		end
	end

	// ==================================================================
	// system time; adjust fires on the high word write, using the low word held
	pta_systime #(
		.PERIOD_W(8),
		.INCV_W(24)
	) u_systime (
		.core_clk(core_clk),
		.reset(reset),
		.inc_period(inc_cfg_reg[31:INC_PERIOD_LSB]),
		.inc_value(inc_cfg_reg[INC_PERIOD_LSB-1:0]),
		.set_high(wr_sys_high),
		.set_high_data(reg_wdata),
		.adj_apply(wr_off_high),
		.adj_neg(reg_wdata[OFF_SIGN_BIT]),
		.adj_mag({reg_wdata[OFF_SIGN_BIT-1:0], off_low_reg}),
		.sys_time(sys_time)
	);

	// ==================================================================
	// frame parser
	logic [10:0] cnt_reg, idx, base_reg, udp_reg, ptp_reg, off;
	logic [7:0] hi_reg, b0_reg, b1_reg, ctl_reg;
	logic [15:0] type_word, seq_sh_reg;
	logic [63:0] src_sh_reg, sof_time_reg;
	pta_kind_t kind_reg;
	logic proto_reg, ptp_ok_reg, have_ctl_reg, in_ptp;

	assign idx = rx_sof ? 11'h0 : cnt_reg;
	assign off = idx - ptp_reg;
	assign type_word = {hi_reg, rx_data};
	assign in_ptp = ptp_ok_reg && !rx_sof && idx >= ptp_reg;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cnt_reg <= 11'h0;
			base_reg <= L2_BASE;
			udp_reg <= 11'h0;
			ptp_reg <= 11'h0;
			hi_reg <= 8'h0;
			kind_reg <= KIND_NONE;
			proto_reg <= 1'b0;
			ptp_ok_reg <= 1'b0;
		end else if (rx_valid) begin
			if (idx != 11'h7ff) cnt_reg <= idx + 11'h1;
			if (rx_sof) begin
				base_reg <= L2_BASE;
				kind_reg <= KIND_NONE;
				proto_reg <= 1'b0;
				ptp_ok_reg <= 1'b0;
			end
			if (idx == base_reg - 11'h2) hi_reg <= rx_data;
			if (idx == base_reg - 11'h1) begin
				if (type_word == ETYPE_VLAN && base_reg == L2_BASE) begin
					base_reg <= VLAN_BASE;
				end else if (type_word == etype_reg) begin
					kind_reg <= KIND_L2;
					ptp_ok_reg <= 1'b1;
					ptp_reg <= base_reg;
				end else if (type_word == ETYPE_IP4) begin
					kind_reg <= KIND_IP4;
				end else if (type_word == ETYPE_IP6) begin
					kind_reg <= KIND_IP6;
				end
			end
			if (kind_reg == KIND_IP4 && idx == base_reg) begin
				udp_reg <= base_reg + {5'h0, rx_data[3:0], 2'b00};
			end
			if (kind_reg == KIND_IP4 && idx == base_reg + IP4_PROTO_OFF) begin
				proto_reg <= rx_data == IP_PROTO_UDP;
			end
			if (kind_reg == KIND_IP6 && idx == base_reg + IP6_NH_OFF) begin
				proto_reg <= rx_data == IP_PROTO_UDP;
				udp_reg <= base_reg + IP6_HDR_LEN;
			end
			if (proto_reg && idx == udp_reg + UDP_PORT_OFF) hi_reg <= rx_data;
			if (proto_reg && idx == udp_reg + UDP_PORT_OFF + 11'h1 &&
				(type_word == UDP_PORT_EVENT || type_word == UDP_PORT_GENERAL)) begin
				ptp_ok_reg <= 1'b1;
				ptp_reg <= udp_reg + UDP_HDR_LEN;
			end
		end
	end

	// header fields sit at the same place for both versions
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			b0_reg <= 8'h0;
			b1_reg <= 8'h0;
			ctl_reg <= 8'h0;
			src_sh_reg <= 64'h0;
			seq_sh_reg <= 16'h0;
			have_ctl_reg <= 1'b0;
		end else if (rx_valid) begin
			if (rx_sof) have_ctl_reg <= 1'b0;
			if (in_ptp && off == PTP_ID_OFF) b0_reg <= rx_data;
			if (in_ptp && off == PTP_VER_OFF) b1_reg <= rx_data;
			if (in_ptp && off >= PTP_SRC_FIRST && off <= PTP_SRC_LAST) begin
				src_sh_reg <= {src_sh_reg[55:0], rx_data};
			end
			if (in_ptp && off >= PTP_SEQ_FIRST && off <= PTP_SEQ_LAST) begin
				seq_sh_reg <= {seq_sh_reg[7:0], rx_data};
			end
			if (in_ptp && off == PTP_CTRL_OFF) begin
				ctl_reg <= rx_data;
				have_ctl_reg <= 1'b1;
			end
		end
	end

	// stamp point is the first byte, as near the line as this block sees
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sof_time_reg <= 64'h0;
		end else if (rx_valid && rx_sof) begin
			sof_time_reg <= sys_time;
		end
	end

	// ==================================================================
	// classification at end of frame
	logic is_v1, is_v2, v2_mode, frame_ptp, type_hit, frame_end, capture, missed;
	logic ts_locked_reg;
	logic [7:0] msg_val, msg_code;

	assign is_v1 = b1_reg[3:0] == PTP_VER1;
	assign is_v2 = b1_reg[3:0] == PTP_VER2;
	assign v2_mode = ctrl_reg[CTRL_V2_BIT];
	assign msg_val = ctrl_reg[CTRL_MSG_LSB+7:CTRL_MSG_LSB];
	assign msg_code = is_v2 ? {4'h0, b0_reg[3:0]} : ctl_reg;
	assign frame_ptp = ptp_ok_reg && have_ctl_reg &&
		((is_v1 && kind_reg == KIND_IP4) || is_v2);
	always_comb begin
		if (v2_mode) begin
			type_hit = is_v2 && (b0_reg[3:0] == msg_val[3:0] ||
				b0_reg[3:0] == V2_PATH_REQ || b0_reg[3:0] == V2_PATH_RESP);
		end else begin
			type_hit = is_v1 && ctl_reg == msg_val;
		end
	end
	assign frame_end = rx_valid && rx_eof && !rx_sof;
	assign capture = frame_end && ctrl_reg[CTRL_EN_BIT] && frame_ptp && type_hit &&
		!ts_locked_reg;
	assign missed = frame_end && ctrl_reg[CTRL_EN_BIT] && frame_ptp && type_hit &&
		ts_locked_reg;

	// ==================================================================
	// timestamp capture and lock
	logic [63:0] rx_ts_reg, rx_src_reg;
	logic [15:0] rx_seq_reg;
	logic [9:0] last_msg_reg;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ts_locked_reg <= 1'b0;
			rx_ts_reg <= 64'h0;
			rx_src_reg <= 64'h0;
			rx_seq_reg <= 16'h0;
		end else if (capture) begin
			ts_locked_reg <= 1'b1;
			rx_ts_reg <= sof_time_reg;
			rx_src_reg <= src_sh_reg;
			rx_seq_reg <= seq_sh_reg;
		end else if (rd_ts_high) begin
			ts_locked_reg <= 1'b0;
		end
	end

	// last seen message: {reserved, event, code}
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			last_msg_reg <= 10'h0;
		end else if (frame_end && frame_ptp) begin
			last_msg_reg <= {pta_msg_class(is_v2, msg_code), msg_code};
		end
	end

	// ==================================================================
	// interrupts: set wins over read-clear
	assign irq_ev = {missed, frame_end && frame_ptp, capture};

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= (rd_stat ? '0 : irq_stat_reg) | irq_ev;
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	// ==================================================================
	// read data, one cycle after the strobe; unmapped reads zero
	always_comb begin
		unique case (reg_addr)
			REG_SYSTIME_LOW: rd_next = sys_time[31:0];
			REG_SYSTIME_HIGH: rd_next = sys_shadow_reg;
			REG_INC_CFG: rd_next = inc_cfg_reg;
			REG_OFF_LOW: rd_next = off_low_reg;
			REG_OFF_HIGH: rd_next = off_high_reg;
			REG_RX_CTRL: rd_next = ctrl_reg;
			REG_RX_TS_LOW: rd_next = rx_ts_reg[31:0];
			REG_RX_TS_HIGH: rd_next = rx_ts_reg[63:32];
			REG_RX_SEQ: rd_next = {16'h0, rx_seq_reg};
			REG_RX_SRC_LOW: rd_next = rx_src_reg[31:0];
			REG_RX_SRC_HIGH: rd_next = rx_src_reg[63:32];
			REG_IRQ_STAT: rd_next = {{(32-IRQ_W){1'b0}}, irq_stat_reg};
			REG_IRQ_MASK: rd_next = {{(32-IRQ_W){1'b0}}, irq_mask_reg};
			REG_ETYPE: rd_next = {16'h0, etype_reg};
			REG_LAST_MSG: rd_next = {21'h0, ts_locked_reg, last_msg_reg};
			default: rd_next = 32'h0;
		endcase
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 32'h0;
		end else begin
			reg_rdata <= reg_read ? rd_next : 32'h0;
		end
	end

	// ==================================================================
	// checks
	property p_lock_hold;
		@(posedge core_clk) disable iff (reset)
		ts_locked_reg && !rd_ts_high |=>
			ts_locked_reg && rx_ts_reg == $past(rx_ts_reg) && rx_seq_reg == $past(rx_seq_reg);
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("locked stamp changed");

	property p_v1_udp4;
		@(posedge core_clk) disable iff (reset)
		capture && is_v1 |-> kind_reg == KIND_IP4 && !v2_mode;
	endproperty
	a_v1_udp4: assert property (p_v1_udp4) else $error("v1 stamped off udp ipv4");

	property p_v1_ctrl;
		@(posedge core_clk) disable iff (reset)
		capture && !v2_mode |-> is_v1 && ctl_reg == msg_val;
	endproperty
	a_v1_ctrl: assert property (p_v1_ctrl) else $error("v1 control mismatch");

	property p_v2_id;
		@(posedge core_clk) disable iff (reset)
		capture && v2_mode |-> is_v2 && (b0_reg[3:0] == msg_val[3:0] ||
			b0_reg[3:0] == V2_PATH_REQ || b0_reg[3:0] == V2_PATH_RESP);
	endproperty
	a_v2_id: assert property (p_v2_id) else $error("v2 id mismatch");

	property p_path_stamp;
		@(posedge core_clk) disable iff (reset)
		frame_end && frame_ptp && v2_mode && is_v2 && ctrl_reg[CTRL_EN_BIT] &&
			!ts_locked_reg && (b0_reg[3:0] == V2_PATH_REQ || b0_reg[3:0] == V2_PATH_RESP)
			|=> ts_locked_reg && rx_ts_reg == $past(sof_time_reg);
	endproperty
	a_path_stamp: assert property (p_path_stamp) else $error("path delay not stamped");

	property p_fields;
		@(posedge core_clk) disable iff (reset)
		capture |=> rx_src_reg == $past(src_sh_reg) && rx_seq_reg == $past(seq_sh_reg);
	endproperty
	a_fields: assert property (p_fields) else $error("identity not latched");

	property p_udp_port;
		@(posedge core_clk) disable iff (reset)
		$rose(ptp_ok_reg) && kind_reg != KIND_L2 |->
			$past(type_word) == UDP_PORT_EVENT || $past(type_word) == UDP_PORT_GENERAL;
	endproperty
	a_udp_port: assert property (p_udp_port) else $error("udp port not ptp");

	property p_v2_class;
		@(posedge core_clk) disable iff (reset)
		frame_end && frame_ptp && is_v2 && b0_reg[3:0] >= V2_UNUSED_HI |=>
			last_msg_reg[9] && !last_msg_reg[8];
	endproperty
	a_v2_class: assert property (p_v2_class) else $error("unused v2 code not flagged");

	property p_stat_clear;
		@(posedge core_clk) disable iff (reset)
		rd_stat && irq_ev == '0 |=> irq_stat_reg == '0 ##1 1'b1;
	endproperty
	a_stat_clear: assert property (p_stat_clear) else $error("status not cleared by read");

endmodule : pta_ptp_core

// ===== pta_rx_src.sv
// receive datapath model: streams one frame of bytes per send call
// assumes the bench fills frame before each call
module pta_rx_src (
	// clock
	input wire logic core_clk,
	// frame bytes
	input wire logic [7:0] frame [0:127],
	// byte stream
	output logic rx_valid,
	output logic rx_sof,
	output logic rx_eof,
	output logic [7:0] rx_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_valid = 1'b0;
		rx_sof = 1'b0;
		rx_eof = 1'b0;
		rx_data = 8'h00;
	end
	// ========
	// gap inserts idle cycles; idle data toggles so no stale byte lingers
	task automatic send(input int n, input bit gap);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			if (gap && i % 5 == 3) begin
				rx_valid <= 1'b0;
				rx_sof <= 1'b0;
				rx_data <= ~rx_data;
				@(posedge core_clk);
			end
			rx_valid <= 1'b1;
			rx_sof <= (i == 0);
			rx_eof <= (i == n - 1);
			rx_data <= frame[i];
		end
		@(posedge core_clk);
		rx_valid <= 1'b0;
		rx_eof <= 1'b0;
		rx_data <= ~rx_data;
	endtask : send
endmodule : pta_rx_src

// ===== pta_systime.sv
// 64-bit system time counter with periodic increment and signed offset adjust
// assumes a free-running clock and one-cycle set and adjust strobes
module pta_systime
	import pta_pkg::*;
#(
	parameter int PERIOD_W = 8,
	parameter int INCV_W = 24
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// increment setup
	input wire logic [PERIOD_W-1:0] inc_period,
	input wire logic [INCV_W-1:0] inc_value,
	// direct load of the high word
	input wire logic set_high,
	input wire logic [31:0] set_high_data,
	// offset adjust
	input wire logic adj_apply,
	input wire logic adj_neg,
	input wire logic [62:0] adj_mag,
	// time out
	output logic [63:0] sys_time
);

	// ==================================================================
	// increment timing
	logic [PERIOD_W-1:0] per_cnt_reg;
	logic inc_fire;
	logic [63:0] inc_amt;
	logic [63:0] adj_amt;
	logic [63:0] time_next;

	assign inc_fire = (inc_period != '0) && (per_cnt_reg >= inc_period - 1'b1);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			per_cnt_reg <= '0;
		end else if (inc_fire || inc_period == '0) begin
			per_cnt_reg <= '0;
		end else begin
			per_cnt_reg <= per_cnt_reg + 1'b1;
		end
	end

	// ==================================================================
	// one adder chain: increment and adjust land in the same edge, never lost
	assign inc_amt = inc_fire ? {{(64-INCV_W){1'b0}}, inc_value} : 64'h0;
	assign adj_amt = adj_apply ? {1'b0, adj_mag} : 64'h0;

	always_comb begin
		if (adj_neg) begin
			time_next = sys_time + inc_amt - adj_amt;
		end else begin
			time_next = sys_time + inc_amt + adj_amt;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sys_time <= 64'h0;
		end else if (set_high) begin
			sys_time <= {set_high_data, time_next[31:0]};
		end else begin
			sys_time <= time_next;
		end
	end

	// ==================================================================
	// checks
	property p_adj_add;
		@(posedge core_clk) disable iff (reset)
		adj_apply && !adj_neg && !set_high |=>
			sys_time == $past(sys_time) + $past(inc_amt) + {1'b0, $past(adj_mag)};
	endproperty
	a_adj_add: assert property (p_adj_add) else $error("offset not added");

	property p_adj_sub;
		@(posedge core_clk) disable iff (reset)
		adj_apply && adj_neg && !set_high |=>
			sys_time == $past(sys_time) + $past(inc_amt) - {1'b0, $past(adj_mag)};
	endproperty
	a_adj_sub: assert property (p_adj_sub) else $error("offset not subtracted");

	property p_inc_step;
		@(posedge core_clk) disable iff (reset)
		inc_fire && !adj_apply && !set_high |=>
			sys_time == $past(sys_time) + {{(64-INCV_W){1'b0}}, $past(inc_value)};
	endproperty
	a_inc_step: assert property (p_inc_step) else $error("wrong increment step");

	property p_inc_gap;
		@(posedge core_clk) disable iff (reset)
		inc_fire && inc_period > 1 ##1 inc_period == $past(inc_period) |-> !inc_fire;
	endproperty
	a_inc_gap: assert property (p_inc_gap) else $error("increments too close");

	property p_idle;
		@(posedge core_clk) disable iff (reset)
		inc_period == '0 && !adj_apply && !set_high |=> sys_time == $past(sys_time);
	endproperty
	a_idle: assert property (p_idle) else $error("time moved while stopped");

endmodule : pta_systime

// ===== test_pta_ptp_core.sv
// bench for the ptp core: software side and frame checks
// assumes pta_rx_src drives the receive stream
module test_pta_ptp_core import pta_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, d, lo, m;
	logic rx_valid, rx_sof, rx_eof, irq;
	logic [7:0] rx_data, val, c;
	logic [7:0] f [0:127];
	logic [63:0] t;
	logic [3:0] v;
	int error_cnt = 0, compares = 0, pb, k;
	bit m2, h;
	pta_ptp_core i_pta_ptp_core (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .rx_valid, .rx_sof, .rx_eof, .rx_data, .irq);
	pta_rx_src i_pta_rx_src (.core_clk, .frame(f), .rx_valid, .rx_sof, .rx_eof, .rx_data);
	initial forever #2 core_clk = ~core_clk;
	// ========
	// bus and compare
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= x;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] x);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1 x = reg_rdata;
	endtask : rd
	task automatic rck(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		rd(a, x);
		chk(x, e);
	endtask : rck
	task automatic wrap_up;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	// ========
	// frames and expectations
	task automatic p16(input int a, input logic [15:0] x);
		f[a] = x[15:8];
		f[a + 1] = x[7:0];
	endtask : p16
	task automatic sf;
		for (int i = 0; i < 128; i++)
			f[i] = 8'($urandom);
		pb = 14;
		p16(12, ETYPE_RESET);
		if (k == 1) begin
			p16(12, ETYPE_VLAN);
			p16(16, ETYPE_RESET);
			pb = 18;
		end else if (k == 2) begin
			p16(12, ETYPE_IP4);
			f[14] = 8'h45;
			f[23] = IP_PROTO_UDP;
			p16(36, UDP_PORT_EVENT);
			pb = 42;
		end else if (k == 3) begin
			p16(12, ETYPE_IP6);
			f[20] = IP_PROTO_UDP;
			p16(56, UDP_PORT_GENERAL);
			pb = 62;
		end
		if (v == PTP_VER2)
			f[pb] = {4'h0, c[3:0]};
		else
			f[pb + 32] = c;
		f[pb + 1] = {4'h0, v};
		i_pta_rx_src.send(pb + 36, 1'($urandom));
		repeat (2) @(posedge core_clk);
	endtask : sf
	function automatic bit hit;
		if (v == PTP_VER1)
			return !m2 && k == 2 && c == val;
		return m2 && (c[3:0] == val[3:0] || c[3:0] inside {4'h2, 4'h3});
	endfunction : hit
	function automatic logic [1:0] cls;
		if (v == PTP_VER1)
			return {c > 8'h04, c < 8'h02};
		return {c[3:0] inside {[4'h4:4'h7], [4'he:4'hf]}, c[3:0] < 4'h4};
	endfunction : cls
	task automatic fr;
		sf();
		h = hit();
		chk(irq, h);
		rd(REG_IRQ_STAT, d);
		chk(d[0], h);
		chk(irq, 1'b0);
		if (v == PTP_VER2 || k == 2) begin
			rd(REG_LAST_MSG, d);
			chk(d[9:0], {cls(), (v == PTP_VER1) ? c : {4'h0, c[3:0]}});
		end
		if (h) begin
			rck(REG_RX_SEQ, {16'h0, f[pb + 30], f[pb + 31]});
			rck(REG_RX_SRC_HIGH, {f[pb + 22], f[pb + 23], f[pb + 24], f[pb + 25]});
			rck(REG_RX_TS_HIGH, t[63:32]);
		end
	endtask : fr
	// ========
	// main sequence
	initial begin
		void'($urandom(32'h3548));
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		rck(REG_INC_CFG, INC_CFG_RESET);
		rck(REG_RX_CTRL, RX_CTRL_RESET);
		rck(REG_ETYPE, {16'h0, ETYPE_RESET});
		rck(8'hfc, 32'h0);
		chk(irq, 1'b0);
		lo = $urandom;
		m = $urandom;
		t = {32'($urandom), 32'h0};
		wr(REG_SYSTIME_HIGH, t[63:32]);
		wr(REG_OFF_LOW, lo);
		wr(REG_OFF_HIGH, {1'b0, m[30:0]});
		t = t + {m[30:0], lo};
		rck(REG_SYSTIME_LOW, t[31:0]);
		rck(REG_SYSTIME_HIGH, t[63:32]);
		wr(REG_OFF_HIGH, {1'b1, m[30:0]});
		t = t - {m[30:0], lo};
		rck(REG_OFF_HIGH, {1'b1, m[30:0]});
		rck(REG_SYSTIME_LOW, t[31:0]);
		rck(REG_SYSTIME_HIGH, t[63:32]);
		// time stands still from here, so every stamp equals t
		wr(REG_IRQ_MASK, 32'h1);
		wr(REG_RX_CTRL, 32'h3);
		k = 0;
		v = PTP_VER2;
		c = 8'h00;
		sf();
		lo = {16'h0, f[pb + 30], f[pb + 31]};
		chk(irq, 1'b1);
		rck(REG_IRQ_STAT, 32'h3);
		k = 1;
		sf();
		rck(REG_IRQ_STAT, 32'h6);
		rck(REG_RX_SEQ, lo);
		rck(REG_RX_TS_LOW, t[31:0]);
		rck(REG_RX_TS_HIGH, t[63:32]);
		for (int i = 0; i < 128; i++) begin
			m2 = i[0];
			v = i[1] ? PTP_VER1 : PTP_VER2;
			c = {4'h0, 4'(i >> 2)};
			k = (i[1] && i[6]) ? 2 : $urandom_range(3);
			val = i[3] ? c : 8'($urandom_range(5));
			wr(REG_RX_CTRL, {16'h0, val, 6'h0, m2, 1'b1});
			fr();
		end
		wr(REG_ETYPE, 32'h0000_1234);
		rck(REG_ETYPE, 32'h0000_1234);
		wr(REG_INC_CFG, {8'h03, 24'h000005});
		rd(REG_SYSTIME_LOW, lo);
		repeat (10) @(posedge core_clk);
		rd(REG_SYSTIME_LOW, m);
		chk(m - lo, 32'h14);
		wrap_up();
	end
	initial begin
		repeat (60000) @(posedge core_clk);
		error_cnt++;
		wrap_up();
	end
endmodule : test_pta_ptp_core
